// ### hw/iep_dev.sv
// Interrupt enable, request timing and idle/power-down control
// Overview of operation
// (R1) Six vectors: two pins, three timers, serial
// (R2) Each source has its own enable bit
// (R3) Global enable bit 7 gates every source
// (R4) Enable bit layout fixed, bit 6 reserved
// (R5) One serial enable gates both serial sources
// (R6) Software never writes ones to bit 6
// (R7) Timer 2 request ORs two software-cleared flags
// (R8) Timers 0/1 set at S5, polled next cycle
// (R9) Timer 2 set at S2, polled same cycle; code sets the flag in the cycle of the event, in any state
// (R10) Idle halts core, peripherals and state kept
// (R11) Idle left by enabled interrupt or reset
// (R12) Reset from idle: two cycles, RAM writes blocked
// (R13) No port write after idle entry instruction
// (R14) Strobes high in idle, low in power-down
// (R15) Power-down stops clock, keeps RAM and registers
// (R16) Power-down left by reset or external interrupt
// (R17) Wake needs enabled level-sensitive external line; code also wakes on an enabled edge-mode line
// (R18) Service starts after oscillator restart delay
// (R19) Oscillator input halved by a flip-flop
// (R20) Serial done requests only with both enables
// (R21) Up/down mode external toggles raise nothing
// (R22) Baud mode rollover sets no overflow flag
// (R23) Request while flag, enable, global all set
`timescale 1ns/10ps
module iep_dev
  import iep_pkg::*;
#(
  parameter int WAKE_CYCLES = IEP_WAKE_CYCLES
)(
  input wire logic mclk_i,           // Oscillator input, 20 MHz
  input wire logic resetn_i,         // Synchronous reset, active low
  input wire logic ext_irq_line0_i,  // External line 0 pin, active low
  input wire logic ext_irq_line1_i,  // External line 1 pin, active low
  input wire logic ext0_edge_i,      // Line 0 edge mode (else level)
  input wire logic ext1_edge_i,      // Line 1 edge mode (else level)
  input wire logic ext_mem_i,        // Program memory is external
  output logic clk_half_o,           // Internal clock, oscillator halved
  output logic addr_latch_strobe_o,  // Address latch strobe pin
  output logic prog_store_strobe_o,  // Program store strobe pin
  output logic port0_oe_n_o,         // Port 0 drive enable, low drives
  output logic port2_addr_o,         // Port 2 shows address, not data
  output logic osc_run_o,            // Oscillator running
  output iep_mode_t mode_o,          // Power mode state
  iep_if.dev bus                     // Core and peripheral side
);
  logic [7:0] ie_r;
  logic div_r;
  logic [2:0] state_r;
  logic ph_r;
  logic [1:0] x0_s, x1_s, xm_s;
  logic x0_prev_r, x1_prev_r;
  logic ext0_flag_r, ext1_flag_r, t0_flag_r, t1_flag_r, t2_ovf_r, t2_ext_r, spi_flag_r;
  logic t0_pend_r, t1_pend_r;
  logic [5:0] src;
  iep_mode_t mode_r;
  logic [$clog2(WAKE_CYCLES+1)-1:0] wake_cnt_r;
  logic [1:0] grace_r;
  logic state2_phase2, state5_phase2;

  // Gated request for one vector
  function automatic logic gate(input logic flag, input logic en, input logic glob);
    gate = flag & en & glob;
  endfunction : gate

  // Oscillator halved; any duty cycle is fine downstream
  always_ff @(posedge mclk_i)
    if (!resetn_i)
      div_r <= 1'b0;
    else if (mode_r != IEP_PDOWN)   // R15
      div_r <= ~div_r;              // R19
  assign clk_half_o = div_r;
  assign osc_run_o = (mode_r != IEP_PDOWN);  // R15

  // State and phase counter of the machine cycle, frozen when stopped
  always_ff @(posedge mclk_i)
    if (!resetn_i)
    begin
      state_r <= 3'h0;
      ph_r <= 1'b0;
    end
    else if (mode_r != IEP_PDOWN)
    begin
      ph_r <= ~ph_r;
      if (ph_r)
        state_r <= (state_r == IEP_S6) ? 3'h0 : state_r + 3'h1;
    end
  assign state2_phase2 = ph_r && state_r == IEP_S2 && mode_r != IEP_PDOWN;
  assign state5_phase2 = ph_r && state_r == IEP_S5 && mode_r != IEP_PDOWN;

  // Enable register; bit 6 is masked on write so it always reads zero
  always_ff @(posedge mclk_i)
    if (!resetn_i)
      ie_r <= IEP_IE_RESET;
    else if (bus.ie_we)
      ie_r <= bus.ie_wdata & IEP_IE_IMPL_MASK;  // R2 R4 R6
  assign bus.ie_rdata = ie_r;

  // Pin synchronisers; the pins are asynchronous
  always_ff @(posedge mclk_i)
    if (!resetn_i)
    begin
      x0_s <= 2'b11;
      x1_s <= 2'b11;
      xm_s <= 2'b00;
      x0_prev_r <= 1'b1;
      x1_prev_r <= 1'b1;
    end
    else
    begin
      x0_s <= {x0_s[0], ext_irq_line0_i};
      x1_s <= {x1_s[0], ext_irq_line1_i};
      xm_s <= {xm_s[0], ext_mem_i};
      x0_prev_r <= x0_s[1];
      x1_prev_r <= x1_s[1];
    end

  // External flags: level follows pin, edge mode latches a falling edge
  // Edge flag drops once a running core has taken it, else it would stick
  always_ff @(posedge mclk_i)
    if (!resetn_i)
    begin
      ext0_flag_r <= 1'b0;
      ext1_flag_r <= 1'b0;
    end
    else
    begin
      if (!ext0_edge_i)
        ext0_flag_r <= ~x0_s[1];                      // R17
      else if (x0_prev_r && !x0_s[1])
        ext0_flag_r <= 1'b1;
      else if (bus.irq_req[IEP_VEC_EXT0] && bus.wake)
        ext0_flag_r <= 1'b0;                          // R23
      if (!ext1_edge_i)
        ext1_flag_r <= ~x1_s[1];
      else if (x1_prev_r && !x1_s[1])
        ext1_flag_r <= 1'b1;
      else if (bus.irq_req[IEP_VEC_EXT1] && bus.wake)
        ext1_flag_r <= 1'b0;                          // R23
    end

  // Timer 0/1 overflows latched, flagged at STATE5_PHASE2, polled next cycle
  always_ff @(posedge mclk_i)
    if (!resetn_i)
    begin
      t0_pend_r <= 1'b0;
      t1_pend_r <= 1'b0;
      t0_flag_r <= 1'b0;
      t1_flag_r <= 1'b0;
    end
    else
    begin
      t0_pend_r <= bus.t0_ovf | (t0_pend_r & ~state5_phase2);
      t1_pend_r <= bus.t1_ovf | (t1_pend_r & ~state5_phase2);
      if (state5_phase2 && (t0_pend_r || bus.t0_ovf))
        t0_flag_r <= 1'b1;                            // R8
      else if (bus.t0_flag_clr)
        t0_flag_r <= 1'b0;
      if (state5_phase2 && (t1_pend_r || bus.t1_ovf))
        t1_flag_r <= 1'b1;                            // R8
      else if (bus.t1_flag_clr)
        t1_flag_r <= 1'b0;
    end

  // Timer 2 flags; software clears them, an up/down external event also toggles t2_ext_r, set wins over clear
  always_ff @(posedge mclk_i)
    if (!resetn_i)
    begin
      t2_ovf_r <= 1'b0;
      t2_ext_r <= 1'b0;
    end
    else
    begin
      if (bus.t2_ovf && !bus.t2_baud)                 // R9 R22
        t2_ovf_r <= 1'b1;
      else if (bus.t2_ovf_clr)
        t2_ovf_r <= 1'b0;                             // R7
      if (bus.t2_ext)
        t2_ext_r <= ~bus.t2_updown | ~t2_ext_r;       // R21
      else if (bus.t2_ext_clr)
        t2_ext_r <= 1'b0;                             // R7
    end

  // Serial peripheral done flag
  always_ff @(posedge mclk_i)
    if (!resetn_i)
      spi_flag_r <= 1'b0;
    else if (bus.spi_done)
      spi_flag_r <= 1'b1;
    else if (bus.spi_done_clr)
      spi_flag_r <= 1'b0;

  // Source levels; timer 2 toggles in up/down mode request nothing
  assign src[IEP_VEC_EXT0] = ext0_flag_r;
  assign src[IEP_VEC_TMR0] = t0_flag_r;
  assign src[IEP_VEC_EXT1] = ext1_flag_r;
  assign src[IEP_VEC_TMR1] = t1_flag_r;
  assign src[IEP_VEC_SER] = bus.uart_flag | (spi_flag_r & bus.spi_irq_en);  // R5 R20
  assign src[IEP_VEC_TMR2] = t2_ovf_r | (t2_ext_r & ~bus.t2_updown);        // R7 R21

  // Requests to the core, one per vector
  always_comb
  begin
    bus.irq_req[IEP_VEC_EXT0] = gate(src[IEP_VEC_EXT0], ie_r[IEP_BIT_EXT0], ie_r[IEP_BIT_GLOBAL]);  // R1 R23
    bus.irq_req[IEP_VEC_TMR0] = gate(src[IEP_VEC_TMR0], ie_r[IEP_BIT_TMR0], ie_r[IEP_BIT_GLOBAL]);
    bus.irq_req[IEP_VEC_EXT1] = gate(src[IEP_VEC_EXT1], ie_r[IEP_BIT_EXT1], ie_r[IEP_BIT_GLOBAL]);
    bus.irq_req[IEP_VEC_TMR1] = gate(src[IEP_VEC_TMR1], ie_r[IEP_BIT_TMR1], ie_r[IEP_BIT_GLOBAL]);
    bus.irq_req[IEP_VEC_SER] = gate(src[IEP_VEC_SER], ie_r[IEP_BIT_SER], ie_r[IEP_BIT_GLOBAL]);   // R5
    bus.irq_req[IEP_VEC_TMR2] = gate(src[IEP_VEC_TMR2], ie_r[IEP_BIT_TMR2], ie_r[IEP_BIT_GLOBAL]);  // R3
  end

  // Power mode machine; wake from power-down only on enabled external lines
  always_ff @(posedge mclk_i)
    if (!resetn_i)
    begin
      mode_r <= IEP_RUN;
      wake_cnt_r <= '0;
    end
    else
      case (mode_r)
        IEP_RUN:
          if (bus.pdown_req)
            mode_r <= IEP_PDOWN;
          else if (bus.idle_req)
            mode_r <= IEP_IDLE;                       // R10
        IEP_IDLE:
          if (|bus.irq_req)
            mode_r <= IEP_RUN;                        // R11
        IEP_PDOWN:
          if (bus.irq_req[IEP_VEC_EXT0] || bus.irq_req[IEP_VEC_EXT1])  // R16
          begin
            mode_r <= IEP_WAKE;
            wake_cnt_r <= '0;
          end
        IEP_WAKE:
          if (wake_cnt_r >= ($bits(wake_cnt_r))'(WAKE_CYCLES - 1))
            mode_r <= IEP_RUN;                        // R18
          else
            wake_cnt_r <= wake_cnt_r + 1'b1;
        default:
          mode_r <= IEP_RUN;
      endcase
  assign mode_o = mode_r;
  assign bus.wake = (mode_r == IEP_RUN);

  // Reset out of idle: RAM writes blocked while reset takes over
  // Mode is back in run after one reset edge, so the load is held through a long reset
  always_ff @(posedge mclk_i)
    if (!resetn_i)
    begin
      if (mode_r == IEP_IDLE || grace_r == IEP_RST_GRACE_CYC)
        grace_r <= IEP_RST_GRACE_CYC;                 // R12
      else
        grace_r <= 2'h0;
    end
    else if (grace_r != 2'h0 && state5_phase2)
      grace_r <= grace_r - 2'h1;
  assign bus.ram_wr_block = (grace_r != 2'h0);

  // Pin states in the low-power modes
  always_comb
  begin
    addr_latch_strobe_o = 1'b1;
    prog_store_strobe_o = 1'b1;
    port0_oe_n_o = xm_s[1];
    port2_addr_o = xm_s[1];
    if (mode_r == IEP_PDOWN || mode_r == IEP_WAKE)
    begin
      addr_latch_strobe_o = 1'b0;                     // R14
      prog_store_strobe_o = 1'b0;
      port2_addr_o = 1'b0;
    end
    else if (mode_r == IEP_RUN)
      port0_oe_n_o = 1'b0;
  end
endmodule : iep_dev

// ### hw/iep_pkg.sv
// Shared constants for the interrupt enable and power mode block
package iep_pkg;
  // Interrupt enable register bit positions
  localparam int IEP_BIT_EXT0 = 0;
  localparam int IEP_BIT_TMR0 = 1;
  localparam int IEP_BIT_EXT1 = 2;
  localparam int IEP_BIT_TMR1 = 3;
  localparam int IEP_BIT_SER = 4;
  localparam int IEP_BIT_TMR2 = 5;
  localparam int IEP_BIT_RSVD = 6;
  localparam int IEP_BIT_GLOBAL = 7;
  localparam logic [7:0] IEP_IE_RESET = 8'h00;
  localparam logic [7:0] IEP_IE_IMPL_MASK = 8'hbf;
  // Vector numbering of the six requests
  localparam int IEP_NVEC = 6;
  localparam int IEP_VEC_EXT0 = 0;
  localparam int IEP_VEC_TMR0 = 1;
  localparam int IEP_VEC_EXT1 = 2;
  localparam int IEP_VEC_TMR1 = 3;
  localparam int IEP_VEC_SER = 4;
  localparam int IEP_VEC_TMR2 = 5;
  // Machine cycle: six states of two phases, twelve oscillator periods
  localparam int IEP_STATES = 6;
  localparam logic [2:0] IEP_S2 = 3'h1;
  localparam logic [2:0] IEP_S5 = 3'h4;
  localparam logic [2:0] IEP_S6 = 3'h5;
  // Idle exit by reset: up to two machine cycles before internal reset
  localparam logic [1:0] IEP_RST_GRACE_CYC = 2'h2;
  // Wake-up delay from power-down
  localparam int IEP_CLK_HZ = 20_000_000;
  localparam int IEP_WAKE_MS = 16;
  localparam int IEP_WAKE_CYCLES = IEP_CLK_HZ / 1000 * IEP_WAKE_MS;
  typedef enum logic [1:0] {IEP_RUN, IEP_IDLE, IEP_PDOWN, IEP_WAKE} iep_mode_t;
endpackage : iep_pkg

// ### hw/iep_if.sv
// Request and enable link between the interrupt block and the core side
`timescale 1ns/10ps
interface iep_if;
  import iep_pkg::*;
  logic [IEP_NVEC-1:0] irq_req;  // Gated requests per vector
  logic wake;                    // Core may run (idle/power-down left)
  logic ram_wr_block;            // Internal RAM writes blocked
  logic [7:0] ie_rdata;          // Interrupt enable register read value
  logic ie_we;                   // Write strobe for the enable register
  logic [7:0] ie_wdata;          // Write data for the enable register
  logic idle_req;                // Software enters idle
  logic pdown_req;               // Software enters power-down
  logic t0_ovf;                  // Timer 0 overflow event
  logic t1_ovf;                  // Timer 1 overflow event
  logic t2_ovf;                  // Timer 2 overflow event
  logic t2_ext;                  // Timer 2 external event
  logic t2_updown;               // Timer 2 up/down mode
  logic t2_baud;                 // Timer 2 baud or clock-out mode
  logic t2_ovf_clr;              // Software clears timer 2 overflow flag
  logic t2_ext_clr;              // Software clears timer 2 external flag
  logic uart_flag;               // Serial port flag level
  logic spi_done;                // Serial peripheral byte done event
  logic spi_done_clr;            // Software clears serial peripheral flag
  logic spi_irq_en;              // Serial peripheral enable
  logic t0_flag_clr;             // Vectoring clears timer 0 flag
  logic t1_flag_clr;             // Vectoring clears timer 1 flag
  modport dev (output irq_req, wake, ram_wr_block, ie_rdata,
               input ie_we, ie_wdata, idle_req, pdown_req, t0_ovf, t1_ovf, t2_ovf, t2_ext,
               t2_updown, t2_baud, t2_ovf_clr, t2_ext_clr, uart_flag, spi_done, spi_done_clr,
               spi_irq_en, t0_flag_clr, t1_flag_clr);
  modport core (input irq_req, wake, ram_wr_block, ie_rdata,
                output ie_we, ie_wdata, idle_req, pdown_req, t0_ovf, t1_ovf, t2_ovf, t2_ext,
                t2_updown, t2_baud, t2_ovf_clr, t2_ext_clr, uart_flag, spi_done, spi_done_clr,
                spi_irq_en, t0_flag_clr, t1_flag_clr);
endinterface : iep_if

// ### hw/iep_core.sv
// Core and peripheral end that drives the interrupt block
`timescale 1ns/10ps
module iep_core
  import iep_pkg::*;
(
  input wire logic mclk_i,        // Clock, 20 MHz
  input wire logic resetn_i,      // Synchronous reset, active low
  input wire logic [7:0] ie_wdata_i,  // Enable value to write
  input wire logic ie_we_i,       // Write enable register
  input wire logic idle_i,        // Enter idle
  input wire logic pdown_i,       // Enter power-down
  input wire logic [5:0] evt_i,   // t0,t1,t2ovf,t2ext,spi,uart events
  input wire logic [1:0] t2_mode_i,  // Up/down, baud mode
  input wire logic spi_en_i,      // Serial peripheral enable
  input wire logic [2:0] clr_i,   // Clear t2 ovf, t2 ext, spi and uart flags
  output logic [5:0] vec_o,       // Pending vectors seen
  output logic run_o,             // Core running
  iep_if.core bus                 // Device side
);
  logic uart_r;
  // Write value with reserved bit forced low
  always_ff @(posedge mclk_i)
    if (!resetn_i)
    begin
      bus.ie_we <= 1'b0;
      bus.ie_wdata <= 8'h00;
    end
    else
    begin
      bus.ie_we <= ie_we_i;
      bus.ie_wdata <= ie_wdata_i & IEP_IE_IMPL_MASK;  // R6
    end
  // Serial port flag kept until its clear
  always_ff @(posedge mclk_i)
    if (!resetn_i)
      uart_r <= 1'b0;
    else if (evt_i[5])
      uart_r <= 1'b1;
    else if (clr_i[2])
      uart_r <= 1'b0;
  assign bus.uart_flag = uart_r;
  assign bus.idle_req = idle_i;                       // R13
  assign bus.pdown_req = pdown_i;                     // R17
  assign bus.t0_ovf = evt_i[0];
  assign bus.t1_ovf = evt_i[1];
  assign bus.t2_ovf = evt_i[2];
  assign bus.t2_ext = evt_i[3];
  assign bus.spi_done = evt_i[4];
  assign bus.t2_updown = t2_mode_i[0];
  assign bus.t2_baud = t2_mode_i[1];
  assign bus.spi_irq_en = spi_en_i;
  assign bus.t2_ovf_clr = clr_i[0];                   // R7
  assign bus.t2_ext_clr = clr_i[1];
  assign bus.spi_done_clr = clr_i[2];
  // Timer 0/1 flags cleared on vectoring
  assign bus.t0_flag_clr = bus.irq_req[IEP_VEC_TMR0] & bus.wake;
  assign bus.t1_flag_clr = bus.irq_req[IEP_VEC_TMR1] & bus.wake;
  // Vector view
  always_ff @(posedge mclk_i)
    if (!resetn_i)
      vec_o <= 6'h00;
    else
      vec_o <= bus.irq_req;
  assign run_o = bus.wake;
endmodule : iep_core

// ### test/iep_assertions.sv
// Concurrent checks on the link between the interrupt block and the core side
`timescale 1ns/10ps
module iep_assertions
  import iep_pkg::*;
(
  input wire logic mclk_i,                   // Clock
  input wire logic resetn_i,                 // Sync reset, active low
  input wire logic [IEP_NVEC-1:0] irq_req,   // Gated requests
  input wire logic [7:0] ie_rdata,           // Enable register value
  input wire logic ie_we,                    // Enable write strobe
  input wire logic [7:0] ie_wdata,           // Enable write data
  input wire logic t0_ovf,                   // Timer 0 event
  input wire logic t2_ovf,                   // Timer 2 overflow event
  input wire logic t2_ext,                   // Timer 2 external event
  input wire logic t2_updown,                // Up/down mode
  input wire logic t2_baud,                  // Baud mode
  input wire logic t2_ovf_clr,               // Overflow flag clear
  input wire logic t2_ext_clr                // External flag clear
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);
  // Timer 2 enabled and no enable write in flight, so gating is steady next cycle
  wire t2_open = ie_rdata[7] & ie_rdata[5] & ~ie_we;
  // Overflow event that should set the flag at once
  sequence t2_set_seq;
    t2_open && t2_ovf && !t2_baud && !t2_ovf_clr;
  endsequence
  // Request idle, toggle under up/down must stay silent one cycle on
  sequence upd_toggle_seq;
    t2_open && t2_updown && t2_ext && !t2_ovf && !irq_req[5] ##1 t2_updown;
  endsequence
  // Pending request with nobody clearing it
  sequence t2_hold_seq;
    irq_req[5] && !t2_ovf_clr && !t2_ext_clr && !ie_we && !t2_updown ##1 !t2_updown;
  endsequence
  AST_IE_WRITE: assert property (ie_we |=> ie_rdata == ($past(ie_wdata) & IEP_IE_IMPL_MASK))
    else $error("enable register did not take the written value");
  AST_RSVD_ZERO: assert property (ie_rdata[IEP_BIT_RSVD] == 1'b0)
    else $error("reserved enable bit reads one");
  AST_GLOBAL_GATE: assert property (!ie_rdata[IEP_BIT_GLOBAL] |-> irq_req == '0)
    else $error("request with global enable clear");
  AST_SRC_GATE: assert property ((irq_req & ~ie_rdata[5:0]) == '0)
    else $error("request from a disabled source");
  AST_T2_SET: assert property (t2_set_seq |=> irq_req[5])
    else $error("timer 2 overflow did not request in the same cycle");
  AST_T2_HOLD: assert property (t2_hold_seq |-> irq_req[5])
    else $error("timer 2 request dropped without a clear");
  AST_BAUD_QUIET: assert property (t2_open && t2_baud && !t2_updown && t2_ovf && !t2_ext && !irq_req[5]
    |=> !irq_req[5])
    else $error("baud mode rollover raised a request");
  AST_UPD_QUIET: assert property (upd_toggle_seq |-> !irq_req[5])
    else $error("up/down toggle raised a request");
  AST_T0_POLL: assert property (ie_rdata[7] && ie_rdata[1] && !ie_we && t0_ovf && !irq_req[1]
    |-> ##[1:13] irq_req[1])
    else $error("timer 0 request late");
endmodule : iep_assertions

// ### test/irq_enable_and_power_modes_tb.sv
// Self-checking bench for the interrupt block and core end pair
`timescale 1ns/10ps
module irq_enable_and_power_modes_tb;
  import iep_pkg::*;
  typedef struct packed {logic [7:0] ie; logic uart; logic [7:0] rd; logic [5:0] req;} iep_row_t;
  localparam int WAKE = 20;
  localparam iep_row_t ROWS [6] = '{'{8'hff, 1'h1, 8'hbf, 6'h10}, '{8'h90, 1'h1, 8'h90, 6'h10},
    '{8'h10, 1'h1, 8'h10, 6'h00}, '{8'h80, 1'h1, 8'h80, 6'h00}, '{8'hef, 1'h1, 8'haf, 6'h00},
    '{8'h40, 1'h0, 8'h00, 6'h00}};
  logic mclk_i, resetn_i, ie_we, spi_en, pin0, pin1, ext_edge, ext_mem, h;
  logic [7:0] ie_wdata;
  logic [5:0] evt, vec;
  logic [1:0] t2_mode, pm;
  logic [2:0] clr;
  logic clk_half, ale, pss, p0_oe_n, p2_addr, osc_run, run;
  iep_mode_t mode;
  int mismatches, n_checks, i, n;
  iep_if bus ();
  iep_dev #(.WAKE_CYCLES(WAKE)) u_iep_dev (.mclk_i(mclk_i), .resetn_i(resetn_i), .ext_irq_line0_i(pin0),
    .ext_irq_line1_i(pin1), .ext0_edge_i(ext_edge), .ext1_edge_i(ext_edge), .ext_mem_i(ext_mem),
    .clk_half_o(clk_half), .addr_latch_strobe_o(ale), .prog_store_strobe_o(pss), .port0_oe_n_o(p0_oe_n),
    .port2_addr_o(p2_addr), .osc_run_o(osc_run), .mode_o(mode), .bus(bus));
  iep_core u_iep_core (.mclk_i(mclk_i), .resetn_i(resetn_i), .ie_wdata_i(ie_wdata), .ie_we_i(ie_we),
    .idle_i(pm[0]), .pdown_i(pm[1]), .evt_i(evt), .t2_mode_i(t2_mode), .spi_en_i(spi_en), .clr_i(clr),
    .vec_o(vec), .run_o(run), .bus(bus));
  iep_assertions u_iep_assertions (.mclk_i(mclk_i), .resetn_i(resetn_i), .irq_req(bus.irq_req),
    .ie_rdata(bus.ie_rdata), .ie_we(bus.ie_we), .ie_wdata(bus.ie_wdata), .t0_ovf(bus.t0_ovf),
    .t2_ovf(bus.t2_ovf), .t2_ext(bus.t2_ext), .t2_updown(bus.t2_updown), .t2_baud(bus.t2_baud),
    .t2_ovf_clr(bus.t2_ovf_clr), .t2_ext_clr(bus.t2_ext_clr));
  // 20 MHz oscillator
  initial
  begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // Settle a few updates past the edge before looking
  task automatic tick(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask : tick
  // Core end adds a cycle, the register answers one edge later
  task automatic wr_ie(input logic [7:0] v);
    @(posedge mclk_i);
    ie_wdata <= v;
    ie_we <= 1'b1;
    @(posedge mclk_i);
    ie_we <= 1'b0;
    tick(1);
  endtask : wr_ie
  task automatic pulse(input int b);
    @(posedge mclk_i);
    evt[b] <= 1'b1;
    @(posedge mclk_i);
    evt[b] <= 1'b0;
    #1;
  endtask : pulse
  task automatic clrp(input int b);
    @(posedge mclk_i);
    clr[b] <= 1'b1;
    @(posedge mclk_i);
    clr[b] <= 1'b0;
    #1;
  endtask : clrp
  task automatic pmode(input int b);
    @(posedge mclk_i);
    pm[b] <= 1'b1;
    @(posedge mclk_i);
    pm[b] <= 1'b0;
    tick(1);
  endtask : pmode
  // Bounded wait for the core to run again
  task automatic wait_run();
    n = 0;
    while (mode !== IEP_RUN && n < 200)
    begin
      tick(1);
      n++;
    end
  endtask : wait_run
  function automatic logic [7:0] rq(input int b);
    return {7'h0, bus.irq_req[b]};
  endfunction : rq
  // Hang guard, tests need well under a thousand cycles
  initial
  begin
    #300000;
    mismatches++;
    $display("watchdog expired");
    finish_test();
  end
  // Main sequence
  initial
  begin
    {mismatches, n_checks} = '0;
    {resetn_i, ie_we, spi_en, ext_edge, ie_wdata, evt, t2_mode, pm, clr} = '0;
    {pin0, pin1, ext_mem} = 3'h7;
    tick(12);
    resetn_i <= 1'b1;
    tick(1);
    check("ie_reset", bus.ie_rdata, IEP_IE_RESET);
    check("req_reset", {2'h0, bus.irq_req}, 8'h00);
    h = clk_half;
    tick(1);
    check("clk_half", {7'h0, clk_half}, {7'h0, ~h});
    $display("reset test done");
    for (i = 0; i < 6; i++)
    begin
      @(posedge mclk_i);
      evt[5] <= ROWS[i].uart;
      wr_ie(ROWS[i].ie);
      check("ie_rdata", bus.ie_rdata, ROWS[i].rd);
      check("irq_req", {2'h0, bus.irq_req}, {2'h0, ROWS[i].req});
    end
    $display("enable rows done");
    wr_ie(8'ha0);
    @(posedge mclk_i);
    t2_mode <= 2'h2;
    pulse(2);
    check("t2_baud", rq(5), 8'h00);
    @(posedge mclk_i);
    t2_mode <= 2'h0;
    pulse(2);
    check("t2_ovf", rq(5), 8'h01);
    tick(20);
    check("t2_held", rq(5), 8'h01);
    check("t2_vec", {2'h0, vec}, 8'h20);
    clrp(0);
    check("t2_ovf_clr", rq(5), 8'h00);
    pulse(3);
    check("t2_ext", rq(5), 8'h01);
    clrp(1);
    check("t2_ext_clr", rq(5), 8'h00);
    @(posedge mclk_i);
    t2_mode <= 2'h1;
    pulse(3);
    check("t2_updown", rq(5), 8'h00);
    clrp(1);
    @(posedge mclk_i);
    t2_mode <= 2'h0;
    $display("timer 2 test done");
    for (i = 0; i < 2; i++)
    begin
      wr_ie(8'h80 | (8'h02 << (2 * i)));
      pulse(i);
      n = 0;
      while (bus.irq_req[1 + 2 * i] !== 1'b1 && n < 14)
      begin
        tick(1);
        n++;
      end
      check("tmr_poll", {7'h0, n < 12}, 8'h01);
    end
    $display("timer 0/1 test done");
    wr_ie(8'h90);
    check("uart_held", rq(4), 8'h01);
    clrp(2);
    check("uart_clr", rq(4), 8'h00);
    pulse(4);
    check("spi_off", rq(4), 8'h00);
    @(posedge mclk_i);
    spi_en <= 1'b1;
    tick(1);
    check("spi_on", rq(4), 8'h01);
    clrp(2);
    check("spi_clr", rq(4), 8'h00);
    $display("serial test done");
    @(posedge mclk_i);
    ext_edge <= 1'b1;
    wr_ie(8'h01);
    @(posedge mclk_i);
    pin0 <= 1'b0;
    tick(4);
    pin0 <= 1'b1;
    check("edge_masked", rq(0), 8'h00);
    wr_ie(8'h81);
    check("edge_req", rq(0), 8'h01);
    tick(1);
    check("edge_taken", rq(0), 8'h00);
    @(posedge mclk_i);
    ext_edge <= 1'b0;
    $display("edge test done");
    wr_ie(8'h81);
    pmode(1);
    check("pd_mode", {6'h0, mode}, {6'h0, IEP_PDOWN});
    check("pd_pins", {2'h0, ale, pss, p0_oe_n, p2_addr, osc_run, run}, 8'h08);
    check("pd_ie", bus.ie_rdata, 8'h81);
    @(posedge mclk_i);
    pin0 <= 1'b0;
    wait_run();
    check("pd_wake_delay", {7'h0, n >= WAKE && n < 200}, 8'h01);
    check("pd_run", {7'h0, run}, 8'h01);
    @(posedge mclk_i);
    pin0 <= 1'b1;
    $display("power-down test done");
    wr_ie(8'h84);
    pmode(0);
    check("idle_mode", {6'h0, mode}, {6'h0, IEP_IDLE});
    check("idle_pins", {2'h0, ale, pss, p0_oe_n, p2_addr, osc_run, run}, 8'h3e);
    check("idle_ie", bus.ie_rdata, 8'h84);
    @(posedge mclk_i);
    pin1 <= 1'b0;
    wait_run();
    check("idle_wake", {6'h0, mode}, {6'h0, IEP_RUN});
    @(posedge mclk_i);
    pin1 <= 1'b1;
    wr_ie(8'h00);
    pmode(0);
    @(posedge mclk_i);
    resetn_i <= 1'b0;
    tick(2);
    resetn_i <= 1'b1;
    tick(1);
    check("ram_block_on", {7'h0, bus.ram_wr_block}, 8'h01);
    check("rst_mode", {6'h0, mode}, {6'h0, IEP_RUN});
    n = 0;
    while (bus.ram_wr_block !== 1'b0 && n < 40)
    begin
      tick(1);
      n++;
    end
    check("ram_block_len", {7'h0, n >= 12 && n <= 24}, 8'h01);
    $display("idle reset test done");
    finish_test();
  end
endmodule : irq_enable_and_power_modes_tb
